// [hdl/flash_ctrl.sv]
// Flash write/erase key lock and read timing controller
`include "flash_ctrl_defs.svh"
module flash_ctrl #(
    parameter int unsigned ERASE_CYCLES = `ERASE_CYCLES_DEF  // Page erase length
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    // External data moves from the core
    input  wire logic        move_wr,
    input  wire logic [15:0] move_addr,
    input  wire logic [7:0]  move_wdata,
    output logic             xram_wr,
    output logic             core_stall,
    // Reads and fetches from the core
    input  wire logic        rd_req,
    input  wire logic [15:0] rd_addr,
    // Flash array side
    output logic             flash_prog,
    output logic             flash_erase,
    output logic      [15:0] flash_addr,
    output logic      [7:0]  flash_wdata,
    output logic             flash_strobe,
    output logic             flash_active,
    output logic      [7:0]  strobe_width_ns,
    // Reset request to the reset controller
    output logic             flash_error_reset
);
    flash_strobe_if sb ();                      // Strobe generator link

    flash_ctrl_pkg::lock_state_t lock_state;    // Key sequence state
    logic                   page_erase_enable;  // Erase select
    logic                   store_write_enable; // Flash write select
    logic                   read_time_select;   // Two-clock read strobe
    logic [3:0]             timing_rsvd;        // Low timing bits, kept
    logic [3:0]             oneshot_period;     // One-shot field
    logic                   busy;               // Write or erase running
    logic [`OP_CNT_W-1:0]   op_cnt;             // Cycles into the operation
    logic [`OP_CNT_W-1:0]   op_last;            // Final cycle of the operation
    logic                   op_done;            // Operation ends this cycle
    logic                   move_flash;         // Move write aimed at flash
    logic                   move_rsvd;          // Move write in reserved area
    logic                   rd_rsvd;            // Read in reserved area
    logic                   flash_go;           // Legal write or erase start
    logic                   flash_bad;          // Attempt while not unlocked
    logic                   key_wr;             // Key register written
    logic [1:0]             lock_code;          // Lock state as read back

    ////////////////////////////////////////////////////////////////////////
    // Request decode

    // Moves only reach flash when the write enable is set
    assign move_flash = move_wr && store_write_enable && !busy;
    assign move_rsvd  = move_addr >= `RSV_LO && move_addr <= `RSV_HI;
    assign rd_rsvd    = rd_req && rd_addr >= `RSV_LO && rd_addr <= `RSV_HI;
    assign flash_go   = move_flash && !move_rsvd
                        && lock_state == flash_ctrl_pkg::UNLOCKED;
    assign flash_bad  = move_flash && !move_rsvd
                        && lock_state != flash_ctrl_pkg::UNLOCKED;
    assign key_wr     = sfr_wr && sfr_addr == `ADDR_KEY_LOCK;

    // Plain moves go to RAM; flash moves never touch it
    assign xram_wr    = move_wr && !store_write_enable && !busy;
    // Core holds while the array is busy
    assign core_stall = busy;

    // Array sleeps whenever the strobe is low; the strobe itself is the
    // power gate, so no separate enable can drift out of step with it
    assign flash_strobe    = sb.strobe;
    assign flash_active    = sb.strobe;
    assign strobe_width_ns = sb.width_ns;

    // Strobe generator inputs; no reads while programming
    assign sb.rd_req = rd_req && !busy && !rd_rsvd;
    assign sb.read_time_select = read_time_select;
    assign sb.period = oneshot_period;

    flash_read_strobe u_strobe (
        .ref_clk (ref_clk),
        .rst     (rst),
        .bus     (sb)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    // Store control: two live bits, the rest ignored
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {page_erase_enable, store_write_enable} <= `RST_STORE_CTRL;
        end else if (sfr_wr && sfr_addr == `ADDR_STORE_CTRL) begin
            page_erase_enable  <= sfr_wdata[`BIT_ERASE_EN];
            store_write_enable <= sfr_wdata[`BIT_WRITE_EN];
        end
    end

    // Read timing: read_time_select plus the low field, upper bits dropped
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {read_time_select, timing_rsvd} <= `RST_READ_TIMING;
        end else if (sfr_wr && sfr_addr == `ADDR_READ_TIMING) begin
            read_time_select <= sfr_wdata[`BIT_READ_TIME];
            timing_rsvd      <= sfr_wdata[3:0];
        end
    end

    // One-shot period: low nibble only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            oneshot_period <= `RST_STROBE_PER;
        end else if (sfr_wr && sfr_addr == `ADDR_STROBE_PER) begin
            oneshot_period <= sfr_wdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Key lock state

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lock_state <= flash_ctrl_pkg::LOCKED;
        end else if (key_wr) begin
            case (lock_state)
                flash_ctrl_pkg::LOCKED: begin
                    // Anything but the first key kills flash writes
                    lock_state <= (sfr_wdata == `KEY_FIRST) ? flash_ctrl_pkg::KEY1
                                                            : flash_ctrl_pkg::DEAD;
                end
                flash_ctrl_pkg::KEY1: begin
                    lock_state <= (sfr_wdata == `KEY_SECOND) ? flash_ctrl_pkg::UNLOCKED
                                                             : flash_ctrl_pkg::DEAD;
                end
                // A key write while open is out of sequence
                default: lock_state <= flash_ctrl_pkg::DEAD;
            endcase
        end else if (flash_bad) begin
            lock_state <= flash_ctrl_pkg::DEAD;
        end else if (op_done && lock_state == flash_ctrl_pkg::UNLOCKED) begin
            // One operation per unlock
            lock_state <= flash_ctrl_pkg::LOCKED;
        end
    end

    // Read code for the lock state
    always_comb begin
        case (lock_state)
            flash_ctrl_pkg::LOCKED:   lock_code = `LOCK_CODE_LOCKED;
            flash_ctrl_pkg::KEY1:     lock_code = `LOCK_CODE_KEY1;
            flash_ctrl_pkg::UNLOCKED: lock_code = `LOCK_CODE_OPEN;
            default:                  lock_code = `LOCK_CODE_DEAD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Write and erase sequencing

    // Erase is far longer, so its count is a parameter for simulation
    assign op_last = flash_erase ? `OP_CNT_W'(ERASE_CYCLES - 1)
                                 : `OP_CNT_W'(`WRITE_CYCLES - 1);
    assign op_done = busy && op_cnt == op_last;

    // Start, hold and end of one array operation
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy        <= 1'b0;
            flash_prog  <= 1'b0;
            flash_erase <= 1'b0;
            op_cnt      <= '0;
        end else if (op_done) begin
            busy        <= 1'b0;
            flash_prog  <= 1'b0;
            flash_erase <= 1'b0;
        end else if (busy) begin
            op_cnt <= op_cnt + 1'b1;
        end else if (flash_go) begin
            // No pre-erase: a program only clears bits
            busy        <= 1'b1;
            op_cnt      <= '0;
            flash_erase <= page_erase_enable;
            flash_prog  <= !page_erase_enable;
        end
    end

    // Address and data captured at start; erase takes the page base
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flash_addr  <= 16'h0000;
            flash_wdata <= 8'h00;
        end else if (flash_go) begin
            flash_wdata <= move_wdata;
            flash_addr  <= page_erase_enable ?
                           {move_addr[15:`PAGE_BITS], `PAGE_BITS'(0)} : move_addr;
        end
    end

    // Reserved area touched by firmware: ask for a device reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flash_error_reset <= 1'b0;
        end else begin
            flash_error_reset <= (move_flash && move_rsvd) || rd_rsvd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read back, one cycle after the read

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                `ADDR_STORE_CTRL:  sfr_rdata <= {6'h00, page_erase_enable,
                                                 store_write_enable};
                `ADDR_STROBE_PER:  sfr_rdata <= {4'h0, oneshot_period};
                `ADDR_READ_TIMING: sfr_rdata <= {3'h0, read_time_select,
                                                 timing_rsvd};
                `ADDR_KEY_LOCK:    sfr_rdata <= {6'h00, lock_code};
                default:           sfr_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_first_key: assert property (@(posedge ref_clk) disable iff (rst)
        key_wr && lock_state == flash_ctrl_pkg::LOCKED && sfr_wdata != `KEY_FIRST
        |=> lock_state == flash_ctrl_pkg::DEAD)
        else $error("wrong first key did not kill");
    // Other register writes may sit between the two keys, so the check
    // starts from the half-open state rather than from two back-to-back
    // key writes, which firmware seldom issues
    a_unlock_seq: assert property (@(posedge ref_clk) disable iff (rst)
        key_wr && sfr_wdata == `KEY_SECOND && lock_state == flash_ctrl_pkg::KEY1
        |=> lock_state == flash_ctrl_pkg::UNLOCKED)
        else $error("key pair did not unlock");
    a_dead_sticky: assert property (@(posedge ref_clk) disable iff (rst)
        lock_state == flash_ctrl_pkg::DEAD |=> lock_state == flash_ctrl_pkg::DEAD)
        else $error("dead state left before reset");
    a_locked_try: assert property (@(posedge ref_clk) disable iff (rst)
        flash_bad && !key_wr |=> lock_state == flash_ctrl_pkg::DEAD && !busy)
        else $error("locked attempt not punished");
    a_relock_after: assert property (@(posedge ref_clk) disable iff (rst)
        op_done && !key_wr |=> !busy && lock_state != flash_ctrl_pkg::UNLOCKED)
        else $error("flash still open after operation");
    a_erase_start: assert property (@(posedge ref_clk) disable iff (rst)
        flash_go && page_erase_enable
        |=> flash_erase && !flash_prog && core_stall && flash_addr[`PAGE_BITS-1:0] == 0)
        else $error("erase did not start on page base");
    a_prog_start: assert property (@(posedge ref_clk) disable iff (rst)
        flash_go && !page_erase_enable |=> flash_prog && flash_wdata == $past(move_wdata))
        else $error("byte program did not start");
    a_ram_route: assert property (@(posedge ref_clk) disable iff (rst)
        move_wr && !store_write_enable && !busy |-> xram_wr ##1 !$rose(busy))
        else $error("plain move went to flash");
    a_key_read: assert property (@(posedge ref_clk) disable iff (rst)
        sfr_rd && sfr_addr == `ADDR_KEY_LOCK |=> sfr_rdata == {6'h00, $past(lock_code)})
        else $error("key read shows wrong state");
    a_rsvd_error: assert property (@(posedge ref_clk) disable iff (rst)
        move_flash && move_rsvd |=> flash_error_reset && !busy)
        else $error("reserved write gave no error reset");
    a_sleep_idle: assert property (@(posedge ref_clk) disable iff (rst)
        busy |=> !flash_active || $past(sb.strobe))
        else $error("array woke while programming");

    c_unlock_write: cover property (@(posedge ref_clk) disable iff (rst)
        lock_state == flash_ctrl_pkg::UNLOCKED ##[1:20] flash_go && !page_erase_enable);
    c_erase: cover property (@(posedge ref_clk) disable iff (rst)
        flash_go && page_erase_enable);
    c_dead: cover property (@(posedge ref_clk) disable iff (rst)
        flash_bad);
    c_rsvd: cover property (@(posedge ref_clk) disable iff (rst)
        rd_rsvd);
endmodule : flash_ctrl

// [hdl/flash_ctrl_defs.svh]
// Constants for the flash write/erase and read timing controller
`ifndef FLASH_CTRL_DEFS_SVH
`define FLASH_CTRL_DEFS_SVH

// Register addresses
`define ADDR_STORE_CTRL   8'h8F
`define ADDR_STROBE_PER   8'hAF
`define ADDR_READ_TIMING  8'hB6
`define ADDR_KEY_LOCK     8'hB7

// Reset values
`define RST_STORE_CTRL    2'h0
`define RST_STROBE_PER    4'hF
`define RST_READ_TIMING   5'h03

// Field positions
`define BIT_WRITE_EN      0
`define BIT_ERASE_EN      1
`define BIT_READ_TIME     4

// Key codes
`define KEY_FIRST         8'hA5
`define KEY_SECOND        8'hF1

// Lock state read codes
`define LOCK_CODE_LOCKED  2'h0
`define LOCK_CODE_KEY1    2'h1
`define LOCK_CODE_OPEN    2'h2
`define LOCK_CODE_DEAD    2'h3

// Reserved area bounds and page size
`define RSV_LO            16'h7E00
`define RSV_HI            16'h7FFF
`define PAGE_BITS         9

// Clock and timing
`define CLK_PERIOD_NS     8'h64
`define ONESHOT_CLK_NS    8'h50
`define ONESHOT_BASE_NS   8'h05
`define ONESHOT_STEP_NS   8'h05
`define WRITE_TIME_NS     38000
`define WRITE_CYCLES      ((`WRITE_TIME_NS + 100 - 1) / 100)
`define ERASE_TIME_MS     16
`define ERASE_CYCLES_DEF  (`ERASE_TIME_MS * 1000000 / 100)
`define OP_CNT_W          18

`endif

// [hdl/flash_ctrl_pkg.sv]
// Types shared by the flash controller modules
package flash_ctrl_pkg;
    // Key sequence progress
    typedef enum logic [1:0] {
        LOCKED,
        KEY1,
        UNLOCKED,
        DEAD
    } lock_state_t;
endpackage : flash_ctrl_pkg

// [hdl/flash_read_strobe.sv]
// Flash read strobe generator with one-shot width cap
`include "flash_ctrl_defs.svh"
module flash_read_strobe (
    input  wire logic     ref_clk,
    input  wire logic     rst,
    flash_strobe_if.gen   bus
);
    logic       hold;          // Second cycle of a two-clock strobe pending
    logic       cap_active;    // One-shot field in force
    logic [7:0] clk_width;     // Width set by the clock alone
    logic [7:0] cap_width;     // One-shot limit
    logic [7:0] next_width;    // Width for the next strobe

    // One-shot only matters on slow clocks or in two-clock mode
    assign cap_active = (`CLK_PERIOD_NS > `ONESHOT_CLK_NS) || bus.read_time_select;
    assign clk_width  = bus.read_time_select ? 8'(`CLK_PERIOD_NS << 1) : `CLK_PERIOD_NS;
    // Limit is base plus period steps
    assign cap_width  = `ONESHOT_BASE_NS + {4'h0, bus.period} * `ONESHOT_STEP_NS;

    // Pick the narrower of clock width and one-shot limit
    always_comb begin
        next_width = clk_width;
        if (cap_active && cap_width < clk_width) begin
            next_width = cap_width;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe timing: one clock, or two when the two-clock select is set
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus.strobe <= 1'b0;
            hold       <= 1'b0;
        end else if (hold) begin
            // Requests during the first strobe cycle are not taken
            bus.strobe <= 1'b1;
            hold       <= 1'b0;
        end else if (bus.rd_req) begin
            bus.strobe <= 1'b1;
            hold       <= bus.read_time_select;
        end else begin
            bus.strobe <= 1'b0;
        end
    end

    // Width report follows each new strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus.width_ns <= 8'h00;
        end else if (bus.rd_req && !hold) begin
            bus.width_ns <= next_width;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_strobe_single: assert property (@(posedge ref_clk) disable iff (rst)
        bus.rd_req && !hold && !bus.read_time_select |=> bus.strobe && !hold)
        else $error("one-clock strobe wrong");
    a_strobe_double: assert property (@(posedge ref_clk) disable iff (rst)
        bus.rd_req && !hold && bus.read_time_select |=> bus.strobe [*2])
        else $error("two-clock strobe wrong");
    a_width_cap: assert property (@(posedge ref_clk) disable iff (rst)
        bus.rd_req && !hold && cap_active |=> bus.width_ns <= $past(cap_width))
        else $error("strobe width above one-shot limit");
    c_two_clock: cover property (@(posedge ref_clk) disable iff (rst)
        bus.rd_req && bus.read_time_select ##1 bus.strobe ##1 bus.strobe);
endmodule : flash_read_strobe

// [hdl/flash_strobe_if.sv]
// Read strobe request and timing between controller and strobe generator
interface flash_strobe_if;
    logic       rd_req;    // Read or fetch this cycle
    logic       read_time_select; // Two-clock strobe select
    logic [3:0] period;    // One-shot period field
    logic       strobe;    // Read strobe to the array
    logic [7:0] width_ns;  // Effective strobe width

    modport ctrl (output rd_req, output read_time_select, output period,
                  input strobe, input width_ns);
    modport gen  (input rd_req, input read_time_select, input period,
                  output strobe, output width_ns);
endinterface : flash_strobe_if

// [sim/core_model.sv]
// Core model issuing external-data moves and flash reads or fetches
module core_model (
    input  wire logic        ref_clk,
    input  wire logic        core_stall,
    input  wire logic        xram_wr,
    input  wire logic        flash_prog,
    input  wire logic        flash_erase,
    input  wire logic        flash_strobe,
    input  wire logic        flash_active,
    input  wire logic        flash_error_reset,
    input  wire logic [7:0]  strobe_width_ns,
    output logic             move_wr,
    output logic      [15:0] move_addr,
    output logic      [7:0]  move_wdata,
    output logic             rd_req,
    output logic      [15:0] rd_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       xram_seen;   // RAM write seen while the move stood
    logic [2:0] op_seen;     // Error, erase, program one cycle after
    logic [2:0] seen;        // Strobe over three cycles after a read
    logic [2:0] act;         // Array awake over the same cycles
    logic       err_seen;    // Error pulse after a read
    logic [7:0] width_seen;  // Reported width after a read
    // Idle values at time zero
    initial begin
        move_wr = 1'h0;
        move_addr = 16'h0000;
        move_wdata = 8'h00;
        rd_req = 1'h0;
        rd_addr = 16'h0000;
    end
    // One move write; released lines show the inverse so stale values never match
    task automatic do_move(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        move_wr <= 1'h1;
        move_addr <= a;
        move_wdata <= d;
        #1 xram_seen = xram_wr;
        @(posedge ref_clk);
        move_wr <= 1'h0;
        move_addr <= ~a;
        move_wdata <= ~d;
        #1 op_seen = {flash_error_reset, flash_erase, flash_prog};
    endtask : do_move
    // One read, strobe watched for three cycles; never faster than every 4 cycles
    task automatic do_read(input logic [15:0] a);
        @(posedge ref_clk);
        rd_req <= 1'h1;
        rd_addr <= a;
        @(posedge ref_clk);
        rd_req <= 1'h0;
        rd_addr <= ~a;
        #1 err_seen = flash_error_reset;
        width_seen = strobe_width_ns;
        for (int i = 0; i < 3; i++) begin
            if (i > 0) begin
                @(posedge ref_clk);
                #1;
            end
            seen[i] = flash_strobe;
            act[i] = flash_active;
        end
    endtask : do_read
endmodule : core_model

// [sim/tb_flash_write_erase_timing.sv]
// Self-checking bench for the flash write/erase and read timing controller
module tb_flash_write_erase_timing;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk = 1'h0;   // 10 MHz system clock
    logic        rst = 1'h1;       // Async reset, high
    logic        sfr_wr = 1'h0;    // Register write strobe
    logic        sfr_rd = 1'h0;    // Register read strobe
    logic [7:0]  sfr_addr = 8'h00; // Register address
    logic [7:0]  sfr_wdata = 8'h00;
    logic [7:0]  sfr_rdata, flash_wdata, strobe_width_ns;
    logic [15:0] move_addr, rd_addr, flash_addr;
    logic [7:0]  move_wdata;
    logic        move_wr, rd_req, xram_wr, core_stall, flash_prog, flash_erase;
    logic        flash_strobe, flash_active, flash_error_reset;
    int          err_count = 0;
    int          checks_done = 0;
    initial forever #50 ref_clk = ~ref_clk;
    flash_ctrl #(.ERASE_CYCLES(20)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .move_wr(move_wr), .move_addr(move_addr),
        .move_wdata(move_wdata), .xram_wr(xram_wr), .core_stall(core_stall),
        .rd_req(rd_req), .rd_addr(rd_addr), .flash_prog(flash_prog),
        .flash_erase(flash_erase), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_strobe(flash_strobe), .flash_active(flash_active),
        .strobe_width_ns(strobe_width_ns), .flash_error_reset(flash_error_reset));
    core_model u_core (.ref_clk(ref_clk), .core_stall(core_stall), .xram_wr(xram_wr),
        .flash_prog(flash_prog), .flash_erase(flash_erase), .flash_strobe(flash_strobe),
        .flash_active(flash_active), .flash_error_reset(flash_error_reset),
        .strobe_width_ns(strobe_width_ns), .move_wr(move_wr), .move_addr(move_addr),
        .move_wdata(move_wdata), .rd_req(rd_req), .rd_addr(rd_addr));
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic results();
        if (err_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    // Four-state compare of any result
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Reset held four cycles, also used mid-run
    task automatic do_reset();
        @(posedge ref_clk);
        rst <= 1'h1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'h0;
    endtask : do_reset
    // Register write, one-cycle strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_wr <= 1'h1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge ref_clk);
        sfr_wr <= 1'h0;
    endtask : wr
    // Register read, data taken the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        sfr_rd <= 1'h1;
        sfr_addr <= a;
        @(posedge ref_clk);
        sfr_rd <= 1'h0;
        #1 chk({8'h00, sfr_rdata}, {8'h00, e});
    endtask : rdchk
    // Key pair opening flash for one operation
    task automatic unlock();
        wr(8'hB7, 8'hA5);
        wr(8'hB7, 8'hF1);
    endtask : unlock
    // Length of the stall, bounded
    task automatic busy_len(input int e);
        int n;
        n = 0;
        while (core_stall !== 1'h0 && n < 1000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(16'(n), 16'(e));
        if (n >= 1000) results();
    endtask : busy_len
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        do_reset();
        rdchk(8'h8F, 8'h00);
        rdchk(8'hAF, 8'h0F);
        rdchk(8'hB6, 8'h03);
        rdchk(8'hB7, 8'h00);
        rdchk(8'h10, 8'h00);
        wr(8'h8F, 8'hFF);
        rdchk(8'h8F, 8'h03);
        wr(8'hAF, 8'hFF);
        rdchk(8'hAF, 8'h0F);
        wr(8'hB6, 8'hE0);
        rdchk(8'hB6, 8'h00);
        wr(8'h8F, 8'h00);
        // Strobe widths at a slow clock, cap from the period field
        u_core.do_read(16'h1000);
        chk(16'(u_core.seen), 16'h0001);
        chk(16'(u_core.act), 16'h0001);
        chk(16'(u_core.width_seen), 16'h0050);
        wr(8'hAF, 8'h07);
        u_core.do_read(16'h1001);
        chk(16'(u_core.width_seen), 16'h0028);
        wr(8'hB6, 8'h10);
        u_core.do_read(16'h1002);
        chk(16'(u_core.seen), 16'h0003);
        chk(16'(u_core.act), 16'h0003);
        chk(16'(u_core.width_seen), 16'h0028);
        u_core.do_read(16'h7F00);
        chk(16'(u_core.seen), 16'h0000);
        chk(16'(u_core.err_seen), 16'h0001);
        // Moves to RAM, page erase, then byte program after the erase
        u_core.do_move(16'h0100, 8'h33);
        chk(16'(u_core.xram_seen), 16'h0001);
        chk(16'(u_core.op_seen), 16'h0000);
        wr(8'hB7, 8'hA5);
        rdchk(8'hB7, 8'h01);
        wr(8'hB7, 8'hF1);
        rdchk(8'hB7, 8'h02);
        wr(8'h8F, 8'h03);
        u_core.do_move(16'h1234, 8'h5A);
        chk(16'(u_core.op_seen), 16'h0002);
        chk(flash_addr, 16'h1200);
        busy_len(20);
        rdchk(8'hB7, 8'h00);
        unlock();
        wr(8'h8F, 8'h01);
        u_core.do_move(16'h1234, 8'h5A);
        chk(16'(u_core.op_seen), 16'h0001);
        chk(flash_addr, 16'h1234);
        chk({8'h00, flash_wdata}, 16'h005A);
        busy_len(380);
        rdchk(8'hB7, 8'h00);
        unlock();
        u_core.do_move(16'h7E10, 8'h11);
        chk(16'(u_core.op_seen), 16'h0004);
        rdchk(8'hB7, 8'h02);
        // Wrong keys and locked attempts from fresh resets, plus a key pair retried while dead
        do_reset();
        wr(8'hB7, 8'hA5);
        wr(8'hB7, 8'h00);
        rdchk(8'hB7, 8'h03);
        unlock();
        rdchk(8'hB7, 8'h03);
        do_reset();
        wr(8'hB7, 8'h12);
        rdchk(8'hB7, 8'h03);
        do_reset();
        wr(8'h8F, 8'h01);
        u_core.do_move(16'h2000, 8'h77);
        chk(16'(u_core.op_seen), 16'h0000);
        rdchk(8'hB7, 8'h03);
        results();
    end
endmodule : tb_flash_write_erase_timing
